// ==== test_triple_timer_event_counter.sv ====
// self-checking bench for the three timer/event counters
// assumes: design, pin model and bound checker compiled before it
`timescale 1ns/100ps
`include "tmr_map.svh"
module test_triple_timer_event_counter;
  import tmr_pkg::*;
  localparam int RTC = 12;
  // marks a read whose value is judged by the caller
  localparam logic [32:0] ANY = 33'h1_0000_0100;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  tmr_vec_t    tmr_pin;
  tmr_vec_t    irq_req;
  logic        wakeup;
  logic        port_a_bit3_pin;
  logic        port_a_bit3_oe;
  int          fails;
  int          cmp_count;
  int          n;
  logic [7:0]  v;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic        p;
  logic [7:0]  ctl[3];
  logic [32:0] exp_q[$];

  triple_timer_event_counter #(.RTC_DIV(RTC)) u_triple_timer_event_counter (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tmr_pin, .irq_req, .wakeup, .port_a_bit3_pin,
    .port_a_bit3_oe
  );
  tmr_pin_model u_tmr_pin_model (.pclk, .pins(tmr_pin));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  task automatic check(input logic [32:0] s, input logic [32:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic end_of_test();
    $display("mismatches %0d of %0d compares", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, input logic [32:0] e,
                     output logic [7:0] r);
    @(posedge pclk);
    if (!w) exp_q.push_back(e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata[7:0];
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, {2'h0, i, 2'h0}, d, ANY, v);
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] d);
    apb(1'b0, {2'h0, i, 2'h0}, 8'h00, {25'h0, d}, v);
  endtask : rd

  task automatic wait_wake(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (wakeup !== 1'b1 && c < 2000);
  endtask : wait_wake

  // mode first, then run, then time two overflows apart
  task automatic per(input logic [7:0] i, input logic [7:0] cv,
                     input int e);
    int c;
    wr(i, cv);
    wr(i, cv | 8'h10);
    wait_wake(c);
    wait_wake(c);
    check(33'(c), 33'(e));
    rd(i, cv | 8'h10);
    wr(i, cv);
  endtask : per

  // each read answer not marked ANY is judged against the oldest note in the queue
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      if (exp_q[0] !== ANY) check({pslverr, prdata}, exp_q[0]);
      void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    end_of_test();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    fails = 0;
    cmp_count = 0;
    n = $urandom(10);
    ctl[0] = `TMR_IDX_T0_CTL;
    ctl[1] = `TMR_IDX_T1_CTL;
    ctl[2] = `TMR_IDX_T2_CTL;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ctl[i]) begin
      rd(ctl[i], 8'h08);
      wr(ctl[i], 8'hEF);
      rd(ctl[i], (i == 1) ? 8'hE8 : 8'hCF);
      wr(ctl[i], 8'h08);
    end
    rd(`TMR_IDX_FLAGS, 8'h00);
    rd(`TMR_IDX_IRQ_EN, 8'h00);
    rd(`TMR_IDX_FDIV_CFG, 8'h00);
    apb(1'b1, 12'h100, 8'h5A, ANY, v);
    apb(1'b0, 12'h100, 8'h00, 33'h1_0000_0000, v);
    apb(1'b0, 12'h039, 8'h00, 33'h1_0000_0000, v);
    lo = 8'($urandom);
    hi = 8'($urandom);
    wr(`TMR_IDX_T0_LOW, lo);
    wr(`TMR_IDX_T0_HIGH, hi);
    wr(`TMR_IDX_T0_LOW, ~lo);
    rd(`TMR_IDX_T0_HIGH, hi);
    rd(`TMR_IDX_T0_LOW, lo);
    wr(`TMR_IDX_T2_COUNT, hi);
    rd(`TMR_IDX_T2_COUNT, hi);
    wr(`TMR_IDX_T0_LOW, 8'hFE);
    wr(`TMR_IDX_T0_HIGH, 8'hFF);
    wr(`TMR_IDX_T1_LOW, 8'hFE);
    wr(`TMR_IDX_T1_HIGH, 8'hFF);
    wr(`TMR_IDX_T2_COUNT, 8'hFE);
    for (int k = 0; k < 8; k++) per(`TMR_IDX_T2_CTL, 8'h80 | 8'(k), 2 << k);
    per(`TMR_IDX_T1_CTL, 8'h80, 8);
    per(`TMR_IDX_T1_CTL, 8'hA0, 2 * RTC);
    per(`TMR_IDX_T0_CTL, 8'h83, 16);
    rd(`TMR_IDX_FLAGS, 8'h07);
    check({30'h0, irq_req}, 33'h0);
    wr(`TMR_IDX_IRQ_EN, 8'h05);
    @(posedge pclk);
    check({30'h0, irq_req}, 33'h5);
    wr(`TMR_IDX_FLAGS, 8'h07);
    @(posedge pclk);
    check({30'h0, irq_req}, 33'h0);
    rd(`TMR_IDX_FLAGS, 8'h00);
    wr(`TMR_IDX_FDIV_CFG, 8'h02);
    wr(`TMR_IDX_T0_CTL, 8'h93);
    @(posedge pclk);
    check({32'h0, port_a_bit3_oe}, 33'h1);
    wait_wake(n);
    repeat (8) @(posedge pclk);
    p = port_a_bit3_pin;
    wait_wake(n);
    repeat (8) @(posedge pclk);
    check({32'h0, port_a_bit3_pin}, {32'h0, ~p});
    wr(`TMR_IDX_FDIV_CFG, 8'h03);
    @(posedge pclk);
    p = port_a_bit3_pin;
    repeat (40) @(posedge pclk);
    check({32'h0, port_a_bit3_pin}, {32'h0, p});
    wr(`TMR_IDX_FDIV_CFG, 8'h00);
    @(posedge pclk);
    check({31'h0, port_a_bit3_oe, port_a_bit3_pin}, 33'h0);
    wr(`TMR_IDX_T0_CTL, 8'h83);
    for (int e = 0; e < 2; e++) begin
      wr(`TMR_IDX_T0_LOW, 8'h00);
      wr(`TMR_IDX_T0_HIGH, 8'h00);
      wr(`TMR_IDX_T0_CTL, 8'h40 | 8'(e << 3));
      wr(`TMR_IDX_T0_CTL, 8'h50 | 8'(e << 3));
      n = 2 + $urandom % 6;
      u_tmr_pin_model.pulses(0, n - 1, 5, 5);
      u_tmr_pin_model.level(0, 1'b1);
      repeat (6) @(posedge pclk);
      rd(`TMR_IDX_T0_HIGH, 8'h00);
      rd(`TMR_IDX_T0_LOW, 8'(n - e));
      wr(`TMR_IDX_T0_CTL, 8'h48);
      u_tmr_pin_model.level(0, 1'b0);
    end
    wr(`TMR_IDX_T2_COUNT, 8'h00);
    wr(`TMR_IDX_T2_CTL, 8'hC8);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr(`TMR_IDX_T2_COUNT, 8'h00);
      if (i != 1) wr(`TMR_IDX_T2_CTL, 8'hD8);
      u_tmr_pin_model.pulses(2, 1, (i == 1) ? 120 : 40, 8);
      rd(`TMR_IDX_T2_CTL, 8'hC8);
      apb(1'b0, {2'h0, `TMR_IDX_T2_COUNT, 2'h0}, 8'h00, ANY, v);
      check({32'h0, v >= 8'h26 && v <= 8'h2A}, 33'h1);
    end
    end_of_test();
  end
endmodule : test_triple_timer_event_counter

// ==== tmr_counter.sv ====
// one up-counter with preload, event/timer/pulse-width modes
// assumes: ticks and pin edges are one-cycle enables on pclk
`timescale 1ns/100ps
`include "tmr_map.svh"
module tmr_counter #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control from the register front end
  tmr_ctl_if.cnt          bus
);
  import tmr_pkg::*;

  logic [W-1:0] count;
  logic [W-1:0] preload;
  pw_state_t    state;
  logic         step;
  logic         start_edge;
  logic         stop_edge;
  logic         is_pulse;

  assign is_pulse   = bus.mode == `TMR_MODE_PULSE;
  assign start_edge = bus.edge_sel ? bus.pin_rise : bus.pin_fall;
  assign stop_edge  = bus.edge_sel ? bus.pin_fall : bus.pin_rise;

  always_comb begin
    step = 1'b0;
    if (bus.mode == `TMR_MODE_EVENT)      step = bus.evt_tick;
    else if (bus.mode == `TMR_MODE_TIMER) step = bus.int_tick;
    else if (is_pulse)
      step = (state == PW_COUNTING) && bus.int_tick;
    step = step && bus.run && !bus.freeze;
  end

  // single shot, run cleared on stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= PW_ARMED;
    else begin
      unique case (state)
        PW_ARMED:
          if (bus.run && is_pulse && start_edge) state <= PW_COUNTING;
        PW_COUNTING:
          if (!bus.run || !is_pulse) state <= PW_ARMED;
          else if (stop_edge)        state <= PW_DONE;
        PW_DONE:
          if (!bus.run) state <= PW_ARMED;
      endcase
    end
  end

  assign bus.run_clear = (state == PW_COUNTING) && is_pulse && bus.run &&
                         stop_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) preload <= '0;
    else if (bus.load) preload <= bus.load_val[W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count        <= '0;
      bus.overflow <= 1'b0;
    end else begin
      bus.overflow <= step && (&count);
      if (bus.load && !bus.run) count <= bus.load_val[W-1:0];
      else if (step && (&count)) count <= preload;
      else if (step) count <= count + W'(1);
    end
  end

  assign bus.count = 16'(count);
endmodule : tmr_counter

// ==== tmr_ctl_if.sv ====
// control and status bundle between the register front end and one counter
// assumes: both ends on pclk
`timescale 1ns/100ps
interface tmr_ctl_if;
  import tmr_pkg::*;
  mode_t       mode;
  logic        edge_sel;
  logic        run;
  logic        evt_tick;
  logic        int_tick;
  logic        pin_rise;
  logic        pin_fall;
  logic        freeze;
  logic        load;
  logic [15:0] load_val;
  logic [15:0] count;
  logic        overflow;
  logic        run_clear;

  modport ctl (output mode, edge_sel, run, evt_tick, int_tick, pin_rise,
               pin_fall, freeze, load, load_val,
               input  count, overflow, run_clear);
  modport cnt (input  mode, edge_sel, run, evt_tick, int_tick, pin_rise,
               pin_fall, freeze, load, load_val,
               output count, overflow, run_clear);
endinterface : tmr_ctl_if

// ==== tmr_map.svh ====
// register indices, field positions, reset values and timing figures
// assumes: included by bare name; holds definitions only
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// register indices (byte address is four times the index)
`define TMR_IDX_T0_HIGH   8'h0C
`define TMR_IDX_T0_LOW    8'h0D
`define TMR_IDX_T0_CTL    8'h0E
`define TMR_IDX_T1_HIGH   8'h0F
`define TMR_IDX_T1_LOW    8'h10
`define TMR_IDX_T1_CTL    8'h11
`define TMR_IDX_T2_COUNT  8'h2C
`define TMR_IDX_T2_CTL    8'h2D
`define TMR_IDX_FLAGS     8'h30
`define TMR_IDX_IRQ_EN    8'h31
`define TMR_IDX_FDIV_CFG  8'h32

// control register fields
`define TMR_CTL_MODE_MSB  7
`define TMR_CTL_MODE_LSB  6
`define TMR_CTL_CLKSEL    5
`define TMR_CTL_RUN       4
`define TMR_CTL_EDGE      3
`define TMR_CTL_PSC_MSB   2
`define TMR_CTL_PSC_LSB   0

// mode codes
`define TMR_MODE_EVENT    2'h1
`define TMR_MODE_TIMER    2'h2
`define TMR_MODE_PULSE    2'h3

// reset values and writable-bit masks
`define TMR_CTL_RESET     8'h08
`define TMR_CTL02_MASK    8'hDF
`define TMR_CTL1_MASK     8'hF8
`define TMR_FDIV_RESET    2'h0
`define TMR_IRQ_EN_RESET  3'h0

// divider output configuration fields
`define TMR_FDIV_SEL      0
`define TMR_FDIV_EN       1

// timing
`define TMR_SYS_HZ        200000000
`define TMR_RTC_HZ        32768
`define TMR_SYS4_STAGE    2

`endif

// ==== tmr_monitor.sv ====
// checker for the bus answers, requests and divider pin of the timer block
// assumes: bound to the top module; one pclk domain, reset active low
`timescale 1ns/100ps
module tmr_monitor #(
  parameter int ADDR_W  = 12,
  parameter int RTC_DIV = 6103
) (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // timer side
  input wire tmr_pkg::tmr_vec_t tmr_pin,
  input wire tmr_pkg::tmr_vec_t irq_req,
  input wire logic              wakeup,
  input wire logic              port_a_bit3_pin,
  input wire logic              port_a_bit3_oe
);
  import tmr_pkg::*;
  logic acc_wr;
  logic rd_setup;
  assign acc_wr   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  err_misalign_a:
    assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  ready_wait_a:
    assert property (psel && penable |-> pready)
    else $error("access phase not answered at once");
  err_mapped_a:
    assert property (psel && penable && paddr == 12'h038 |-> !pslverr)
    else $error("mapped register refused");
  rd_unmapped_a:
    assert property (rd_setup && paddr[1:0] != 2'h0 |=> prdata == 32'h0)
    else $error("refused read returned data");
  rd_upper_a:
    assert property (prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  rd_hold_a:
    assert property (!rd_setup |=> $stable(prdata))
    else $error("read data changed without a read");
  pin_oe_a:
    assert property (port_a_bit3_pin |-> port_a_bit3_oe)
    else $error("divider pin high while not enabled");
  oe_write_a:
    assert property ($changed(port_a_bit3_oe) |-> $past(acc_wr))
    else $error("divider enable moved without a write");
  irq_cause_a:
    assert property ($rose(|irq_req) |-> wakeup || $past(acc_wr))
    else $error("request rose without overflow or write");

  cover property (wakeup);
  cover property (psel && penable && pslverr);
  cover property ($rose(port_a_bit3_pin));
endmodule : tmr_monitor

bind triple_timer_event_counter tmr_monitor #(
  .ADDR_W(ADDR_W),
  .RTC_DIV(RTC_DIV)
) u_tmr_monitor (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .tmr_pin, .irq_req, .wakeup, .port_a_bit3_pin,
  .port_a_bit3_oe
);

// ==== tmr_pin_model.sv ====
// partner model: event and pulse sources on the three timer pins
// assumes: commanded by the bench through its tasks; pins idle low
`timescale 1ns/100ps
module tmr_pin_model (
  // clock
  input  wire logic         pclk,
  // pins toward the timer block
  output tmr_pkg::tmr_vec_t pins
);
  import tmr_pkg::*;
  initial pins = 3'h0;

  task automatic level(input int idx, input logic lv);
    tmr_vec_t nxt;
    @(posedge pclk);
    nxt = pins;
    nxt[idx] = lv;
    pins <= nxt;
  endtask : level

  // whole pulses, wider than the synchroniser needs
  task automatic pulses(input int idx, input int n, input int hi,
                        input int lo);
    for (int i = 0; i < n; i++) begin
      level(idx, 1'b1);
      repeat (hi - 1) @(posedge pclk);
      level(idx, 1'b0);
      repeat (lo - 1) @(posedge pclk);
    end
  endtask : pulses
endmodule : tmr_pin_model

// ==== tmr_pkg.sv ====
// shared types of the timer/event counter block
// assumes: nothing beyond the map header
package tmr_pkg;
  typedef logic [1:0] mode_t;
  typedef logic [2:0] tmr_vec_t;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {PW_ARMED, PW_COUNTING, PW_DONE} pw_state_t;
endpackage : tmr_pkg

// ==== tmr_prescaler.sv ====
// free-running prescaler: one-cycle enables at pclk / 2^k and a slow tick
// assumes: single pclk domain, asynchronous active-low reset
`timescale 1ns/100ps
module tmr_prescaler #(
  parameter int RTC_DIV = 6103
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // enables
  output logic [7:0]      stage_tick,
  output logic            rtc_tick
);
  import tmr_pkg::*;
  localparam int RW = $clog2(RTC_DIV + 1);

  logic [6:0]    div_cnt;
  logic [RW-1:0] rtc_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_cnt <= 7'h00;
    else          div_cnt <= div_cnt + 7'h01;
  end

  assign stage_tick[0] = 1'b1;
  for (genvar k = 1; k < 8; k++) begin : g_stage
    assign stage_tick[k] = &div_cnt[k-1:0];
  end

  // slow source stands in for the 32768Hz oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_cnt  <= '0;
      rtc_tick <= 1'b0;
    end else if (rtc_cnt == RW'(RTC_DIV - 1)) begin
      rtc_cnt  <= '0;
      rtc_tick <= 1'b1;
    end else begin
      rtc_cnt  <= rtc_cnt + RW'(1);
      rtc_tick <= 1'b0;
    end
  end
endmodule : tmr_prescaler

// ==== triple_timer_event_counter.sv ====
// three timer/event counters behind an APB slave, with divider output
// assumes: pclk at 200 MHz; timer pins asynchronous to pclk
//
// Behaviour
// - counter 0 is 16-bit up-counter from its pin or prescaled clock.
// - counter 1 internal clock is clock/4 or the 32768Hz source.
// - counter 2 is 8-bit up-counter from its pin or prescaled clock.
// - low byte write fills buffer; high byte write loads both into preload.
// - high byte read returns high and captures low into buffer.
// - counter 2 write sets preload; read returns the live count.
// - event mode counts pin edges; timer mode counts internal ticks.
// - pulse width mode counts internal ticks while pin level persists.
// - counters run up to all ones of their width.
// - overflow reloads from preload and sets the counter's flag.
// - pulse width starts on chosen edge, stops on return, clears run.
// - pulse width is single shot until software sets run again.
// - pulse width overflow reloads and flags like other modes.
// - run bit 4 enables; only software clears it outside pulse mode.
// - any counter overflow is a wake-up source.
// - one of counters 0 and 1 drives the divider output pin.
// - divider output enable bit turns the pin output on and off.
// - clearing an interrupt enable suppresses that counter's request.
// - preload write on stopped counter also loads the counter.
// - counter clock is blocked while the counter is being read.
// - mode bits 7:6 code 01 event, 10 timer, 11 pulse width.
// - prescaler field divides the clock by two to its value.
// - edge bit 3 picks falling or rising edge and pulse polarity.
// - control 1 bit 5 picks clock/4 or the 32768Hz source.
`timescale 1ns/100ps
`include "tmr_map.svh"
module triple_timer_event_counter #(
  parameter int ADDR_W  = 12,
  parameter int RTC_DIV = `TMR_SYS_HZ / `TMR_RTC_HZ
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // external timer pins
  input  wire tmr_pkg::tmr_vec_t tmr_pin,
  // requests and wake-up
  output tmr_pkg::tmr_vec_t      irq_req,
  output logic                   wakeup,
  // divider output on port a bit 3
  output logic                   port_a_bit3_pin,
  output logic                   port_a_bit3_oe
);
  import tmr_pkg::*;

  // bus decode
  logic [7:0]   idx;
  logic         aligned;
  logic         mapped;
  logic         setup_ph;
  logic         access_ph;
  logic         wr_ok;
  logic         rd_setup;
  reg_byte_t    wbyte;
  reg_byte_t    rd_mux;

  // register state
  reg_byte_t    ctl [3];
  reg_byte_t    hold_lo [2];
  tmr_vec_t     flags;
  tmr_vec_t     irq_en;
  logic [1:0]   fdiv_cfg;
  logic         fdiv_level;

  // pin conditioning
  tmr_vec_t     pin_meta;
  tmr_vec_t     pin_sync;
  tmr_vec_t     pin_last;
  tmr_vec_t     rise;
  tmr_vec_t     fall;

  // per-counter links
  logic [15:0]  cnt_val [3];
  tmr_vec_t     ovf;
  tmr_vec_t     run_clr;
  tmr_vec_t     ld;
  tmr_vec_t     frz;
  tmr_vec_t     int_tick;
  logic [15:0]  ld_val [3];
  logic [7:0]   stage_tick;
  logic         rtc_tick;

  assign idx       = paddr[9:2];
  assign aligned   = (paddr[1:0] == 2'h0) &&
                     (ADDR_W <= 10 || paddr[ADDR_W-1:10] == '0);
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign wbyte     = pwdata[7:0];

  always_comb begin
    unique case (idx)
      `TMR_IDX_T0_HIGH, `TMR_IDX_T0_LOW, `TMR_IDX_T0_CTL,
      `TMR_IDX_T1_HIGH, `TMR_IDX_T1_LOW, `TMR_IDX_T1_CTL,
      `TMR_IDX_T2_COUNT, `TMR_IDX_T2_CTL,
      `TMR_IDX_FLAGS, `TMR_IDX_IRQ_EN, `TMR_IDX_FDIV_CFG:
        mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready   = 1'b1;
  assign pslverr  = access_ph && !mapped;
  assign wr_ok    = access_ph && pwrite && mapped;
  assign rd_setup = setup_ph && !pwrite && mapped;

  // two-flop synchronisers, then a third stage for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_last <= 3'h0;
    end else begin
      pin_meta <= tmr_pin;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  assign rise = pin_sync & ~pin_last;
  assign fall = ~pin_sync & pin_last;

  tmr_prescaler #(
    .RTC_DIV    (RTC_DIV)
  ) u_prescaler (
    .pclk       (pclk),
    .presetn    (presetn),
    .stage_tick (stage_tick),
    .rtc_tick   (rtc_tick)
  );

  assign int_tick[0] = stage_tick[ctl[0][`TMR_CTL_PSC_MSB:`TMR_CTL_PSC_LSB]];
  assign int_tick[2] = stage_tick[ctl[2][`TMR_CTL_PSC_MSB:`TMR_CTL_PSC_LSB]];
  assign int_tick[1] = ctl[1][`TMR_CTL_CLKSEL] ? rtc_tick
                                               : stage_tick[`TMR_SYS4_STAGE];

  // high byte write loads buffered pair
  assign ld[0]     = wr_ok && idx == `TMR_IDX_T0_HIGH;
  assign ld[1]     = wr_ok && idx == `TMR_IDX_T1_HIGH;
  assign ld_val[0] = {wbyte, hold_lo[0]};
  assign ld_val[1] = {wbyte, hold_lo[1]};
  assign ld[2]     = wr_ok && idx == `TMR_IDX_T2_COUNT;
  assign ld_val[2] = {8'h00, wbyte};

  // clock blocked across the read transfer
  assign frz[0] = psel && !pwrite && idx == `TMR_IDX_T0_HIGH;
  assign frz[1] = psel && !pwrite && idx == `TMR_IDX_T1_HIGH;
  assign frz[2] = psel && !pwrite && idx == `TMR_IDX_T2_COUNT;

  for (genvar i = 0; i < 3; i++) begin : g_cnt
    tmr_ctl_if ifc ();

    assign ifc.mode     = ctl[i][`TMR_CTL_MODE_MSB:`TMR_CTL_MODE_LSB];
    assign ifc.edge_sel = ctl[i][`TMR_CTL_EDGE];
    assign ifc.run      = ctl[i][`TMR_CTL_RUN];
    assign ifc.evt_tick = ctl[i][`TMR_CTL_EDGE] ? fall[i] : rise[i];
    assign ifc.int_tick = int_tick[i];
    assign ifc.pin_rise = rise[i];
    assign ifc.pin_fall = fall[i];
    assign ifc.freeze   = frz[i];
    assign ifc.load     = ld[i];
    assign ifc.load_val = ld_val[i];
    assign cnt_val[i]   = ifc.count;
    assign ovf[i]       = ifc.overflow;
    assign run_clr[i]   = ifc.run_clear;

    tmr_counter #(
      .W       ((i == 2) ? 8 : 16)
    ) u_counter (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (ifc)
    );
  end

  // software owns run; hardware clears it only after a pulse measure
  for (genvar i = 0; i < 3; i++) begin : g_ctl
    localparam logic [7:0] CTL_IDX =
      (i == 0) ? `TMR_IDX_T0_CTL : (i == 1) ? `TMR_IDX_T1_CTL
                                            : `TMR_IDX_T2_CTL;
    localparam logic [7:0] CTL_MASK =
      (i == 1) ? `TMR_CTL1_MASK : `TMR_CTL02_MASK;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctl[i] <= `TMR_CTL_RESET;
      else if (wr_ok && idx == CTL_IDX) ctl[i] <= wbyte & CTL_MASK;
      else if (run_clr[i]) ctl[i][`TMR_CTL_RUN] <= 1'b0;
    end
  end

  // one low-byte buffer per 16-bit counter, shared by write and read
  for (genvar i = 0; i < 2; i++) begin : g_hold
    localparam logic [7:0] HI_IDX =
      (i == 0) ? `TMR_IDX_T0_HIGH : `TMR_IDX_T1_HIGH;
    localparam logic [7:0] LO_IDX =
      (i == 0) ? `TMR_IDX_T0_LOW : `TMR_IDX_T1_LOW;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hold_lo[i] <= 8'h00;
      else if (wr_ok && idx == LO_IDX) hold_lo[i] <= wbyte;
      else if (rd_setup && idx == HI_IDX) hold_lo[i] <= cnt_val[i][7:0];
    end
  end

  // sticky flags; an overflow beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flags <= 3'h0;
    else if (wr_ok && idx == `TMR_IDX_FLAGS)
      flags <= (flags & ~wbyte[2:0]) | ovf;
    else flags <= flags | ovf;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_en <= `TMR_IRQ_EN_RESET;
    else if (wr_ok && idx == `TMR_IDX_IRQ_EN) irq_en <= wbyte[2:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fdiv_cfg <= `TMR_FDIV_RESET;
    else if (wr_ok && idx == `TMR_IDX_FDIV_CFG) fdiv_cfg <= wbyte[1:0];
  end

  assign irq_req = flags & irq_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wakeup <= 1'b0;
    else          wakeup <= |ovf;
  end

  // one selected counter toggles the divider level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fdiv_level <= 1'b0;
    else if (ovf[fdiv_cfg[`TMR_FDIV_SEL]]) fdiv_level <= ~fdiv_level;
  end

  assign port_a_bit3_pin = fdiv_level && fdiv_cfg[`TMR_FDIV_EN];
  assign port_a_bit3_oe  = fdiv_cfg[`TMR_FDIV_EN];

  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      // high read returns live high byte
      `TMR_IDX_T0_HIGH:  rd_mux = cnt_val[0][15:8];
      `TMR_IDX_T0_LOW:   rd_mux = hold_lo[0];
      `TMR_IDX_T0_CTL:   rd_mux = ctl[0];
      `TMR_IDX_T1_HIGH:  rd_mux = cnt_val[1][15:8];
      `TMR_IDX_T1_LOW:   rd_mux = hold_lo[1];
      `TMR_IDX_T1_CTL:   rd_mux = ctl[1];
      `TMR_IDX_T2_COUNT: rd_mux = cnt_val[2][7:0];
      `TMR_IDX_T2_CTL:   rd_mux = ctl[2];
      `TMR_IDX_FLAGS:    rd_mux = {5'h00, flags};
      `TMR_IDX_IRQ_EN:   rd_mux = {5'h00, irq_en};
      `TMR_IDX_FDIV_CFG: rd_mux = {6'h00, fdiv_cfg};
      default:           rd_mux = 8'h00;
    endcase
  end

  // read data is latched in the setup cycle so it is stable in access;
  // refused reads return zero rather than an aliased register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h00000000;
    else if (setup_ph && !pwrite)
      prdata <= {24'h000000, mapped ? rd_mux : 8'h00};
  end
endmodule : triple_timer_event_counter
